// ---- ccf_pkg.sv ----
package ccf_pkg;

	// ==========================================================
	// Sizes
	// ==========================================================
	localparam int CCF_NUM_CHAN   = 16;
	localparam int CCF_CHAN_AW    = 4;
	localparam int CCF_WORD_W     = 24;
	localparam int CCF_BUS_AW     = 8;
	localparam int CCF_BUS_DW     = 32;
	localparam int CCF_SEL_W      = 5;

	// ==========================================================
	// Register byte addresses
	// ==========================================================
	localparam logic [7:0] CCF_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] CCF_ADDR_THR_LO = 8'h04;
	localparam logic [7:0] CCF_ADDR_THR_HI = 8'h08;
	localparam logic [7:0] CCF_ADDR_STATUS = 8'h0C;
	localparam logic [7:0] CCF_ADDR_MASK   = 8'h10;
	localparam logic [7:0] CCF_ADDR_LIVE   = 8'h14;
	// Channel words: base + 4 * channel
	localparam logic [1:0] CCF_CHAN_PAGE   = 2'h1;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int CCF_CH_ENABLE_BIT  = 23;
	localparam int CCF_CH_THRES_BIT   = 18;
	localparam int CCF_CH_AINP_LSB    = 13;
	localparam int CCF_CH_PDSW_BIT    = 9;
	localparam int CCF_CTRL_FIFO_BIT  = 0;
	localparam int CCF_CTRL_STBY_BIT  = 1;
	localparam int CCF_ST_BELOW_BIT   = 0;
	localparam int CCF_ST_ABOVE_BIT   = 1;
	localparam int CCF_ST_W           = 2;
	localparam int CCF_LIVE_SW_BIT    = 0;
	localparam int CCF_LIVE_OK_BIT    = 1;
	localparam int CCF_LIVE_SEL_LSB   = 8;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [23:0] CCF_RST_CHAN0  = 24'h80_0000;
	localparam logic [23:0] CCF_RST_CHANM  = 24'h00_0000;
	localparam logic [1:0]  CCF_RST_CTRL   = 2'h0;
	localparam logic [23:0] CCF_RST_THR_LO = 24'h00_0000;
	localparam logic [23:0] CCF_RST_THR_HI = 24'hFF_FFFF;
	localparam logic [1:0]  CCF_RST_ST     = 2'h0;

	// ==========================================================
	// Power modes from the mode controller
	// ==========================================================
	typedef enum logic [1:0] {
		CCF_PM_ACTIVE,
		CCF_PM_STANDBY,
		CCF_PM_POWERDOWN,
		CCF_PM_IDLE
	} ccf_pmode_t;

endpackage : ccf_pkg

// ---- ccf_chan_mem.sv ----
module ccf_chan_mem
	import ccf_pkg::*;
#(
	parameter int NUM_CHAN = CCF_NUM_CHAN
)
(
	// Clock and reset
	input  wire logic                    clk_sys_i,
	input  wire logic                    sys_rst_i,
	// Bus side
	input  wire logic [CCF_BUS_AW-1:0]   addr_i,
	input  wire logic [CCF_BUS_DW-1:0]   wr_data_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	input  wire logic [CCF_BUS_DW-1:0]   other_rd_data_i,
	output logic      [CCF_BUS_DW-1:0]   rd_data_o,
	// Sequencer side
	input  wire logic [CCF_CHAN_AW-1:0]  seq_chan_i,
	output logic      [CCF_WORD_W-1:0]   seq_word_o
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [NUM_CHAN-1:0][CCF_WORD_W-1:0] words;
		logic [CCF_BUS_DW-1:0]               rd_data;
		logic [CCF_WORD_W-1:0]               seq_word;
	} ccf_mem_state_t;

	ccf_mem_state_t state_reg;
	ccf_mem_state_t state_next;

	logic                   page_hit;
	logic [CCF_CHAN_AW-1:0] bus_chan;

	assign page_hit = (addr_i[7:6] == CCF_CHAN_PAGE);
	assign bus_chan = addr_i[5:2];

	always_comb
	begin
		state_next = state_reg;
		if (wr_i && page_hit && (32'(bus_chan) < NUM_CHAN))
		begin
			state_next.words[bus_chan] = wr_data_i[CCF_WORD_W-1:0];
		end
		// Unmapped read gives zero from the top's side data
		state_next.rd_data = '0;
		if (rd_i)
		begin
			if (page_hit && (32'(bus_chan) < NUM_CHAN))
			begin
				state_next.rd_data = {8'h00, state_reg.words[bus_chan]};
			end
			else if (!page_hit)
			begin
				state_next.rd_data = other_rd_data_i;
			end
		end
		state_next.seq_word = state_reg.words[seq_chan_i];
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < NUM_CHAN; i++)
			begin
				state_reg.words[i] <= (i == 0) ? CCF_RST_CHAN0
				                                : CCF_RST_CHANM;
			end
			state_reg.rd_data  <= '0;
			state_reg.seq_word <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign rd_data_o  = state_reg.rd_data;
	assign seq_word_o = state_reg.seq_word;

endmodule : ccf_chan_mem

// ---- ccf_thresh_cmp.sv ----
module ccf_thresh_cmp
	import ccf_pkg::*;
#(
	parameter int DATA_W = CCF_WORD_W
)
(
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              sys_rst_i,
	// Result and limits
	input  wire logic              valid_i,
	input  wire logic [DATA_W-1:0] data_i,
	input  wire logic [DATA_W-1:0] low_i,
	input  wire logic [DATA_W-1:0] high_i,
	input  wire logic              watch_en_i,
	// One-cycle crossing pulses
	output logic                   below_o,
	output logic                   above_o
);

	typedef struct packed {
		logic below;
		logic above;
	} ccf_cmp_state_t;

	ccf_cmp_state_t state_reg;
	ccf_cmp_state_t state_next;

	always_comb
	begin
		state_next.below = valid_i && watch_en_i && (data_i < low_i);
		state_next.above = valid_i && watch_en_i && (data_i > high_i);
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign below_o = state_reg.below;
	assign above_o = state_reg.above;

endmodule : ccf_thresh_cmp

// ---- ccf_chan_cfg.sv ----
// Functional notes
// - Bit set, channel converting: close switch
// - Bit clear: switch stays open
// - Power-down forces the switch open
// - Standby without allow bit: switch open
// - Watch bit set: compare results to limits
// - FIFO disabled: no threshold watching
// - Five-bit field picks positive input
// - Input code map, reserved codes flagged
//
// Design decisions made here: the plain strobed port and the address map.
module ccf_chan_cfg
	import ccf_pkg::*;
#(
	parameter int NUM_CHAN = CCF_NUM_CHAN
)
(
	// Clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   sys_rst_i,
	// Register port
	input  wire logic [CCF_BUS_AW-1:0]  addr_i,
	input  wire logic [CCF_BUS_DW-1:0]  wr_data_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [CCF_BUS_DW-1:0]  rd_data_o,
	// Sequencer and mode controller
	input  wire logic                   conv_active_i,
	input  wire logic [CCF_CHAN_AW-1:0] conv_chan_i,
	input  wire logic [1:0]             power_mode_i,
	// Conversion results
	input  wire logic                   result_valid_i,
	input  wire logic [CCF_WORD_W-1:0]  result_data_i,
	// Analog controls
	output logic                        low_side_switch_pin_o,
	output logic      [CCF_SEL_W-1:0]   chan_positive_input_sel_o,
	output logic                        positive_input_ok_o,
	// Interrupt
	output logic                        irq_o
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic                  fifo_en;
		logic                  standby_switch_allow;
		logic [CCF_WORD_W-1:0] threshold_low_value;
		logic [CCF_WORD_W-1:0] threshold_high_value;
		logic [CCF_ST_W-1:0]   status;
		logic [CCF_ST_W-1:0]   mask;
		logic                  switch_on;
		logic [CCF_SEL_W-1:0]  pos_sel;
		logic                  pos_ok;
		logic                  irq;
	} ccf_state_t;

	ccf_state_t state_reg;
	ccf_state_t state_next;

	logic [CCF_WORD_W-1:0] chan_word;
	logic [CCF_BUS_DW-1:0] other_rd_data;
	logic                  cross_below;
	logic                  cross_above;
	logic                  chan_low_side_switch_on;
	logic                  chan_threshold_watch_en;
	logic [CCF_SEL_W-1:0]  chan_sel;
	logic [CCF_ST_W-1:0]   events;
	logic [CCF_ST_W-1:0]   clr;
	logic                  sel_reserved;
	ccf_pmode_t            pmode;

	assign pmode = ccf_pmode_t'(power_mode_i);

	// ==========================================================
	// Channel words
	// ==========================================================
	// Word fetch adds a cycle; conv_chan_i must settle first
	ccf_chan_mem #(
		.NUM_CHAN        (NUM_CHAN)
	) u_mem (
		.clk_sys_i       (clk_sys_i),
		.sys_rst_i       (sys_rst_i),
		.addr_i          (addr_i),
		.wr_data_i       (wr_data_i),
		.wr_i            (wr_i),
		.rd_i            (rd_i),
		.other_rd_data_i (other_rd_data),
		.rd_data_o       (rd_data_o),
		.seq_chan_i      (conv_chan_i),
		.seq_word_o      (chan_word)
	);

	assign chan_low_side_switch_on = chan_word[CCF_CH_PDSW_BIT];
	assign chan_threshold_watch_en = chan_word[CCF_CH_THRES_BIT];
	assign chan_sel = chan_word[CCF_CH_AINP_LSB +: CCF_SEL_W];

	// ==========================================================
	// Threshold watch
	// ==========================================================
	ccf_thresh_cmp #(
		.DATA_W     (CCF_WORD_W)
	) u_cmp (
		.clk_sys_i  (clk_sys_i),
		.sys_rst_i  (sys_rst_i),
		.valid_i    (result_valid_i),
		.data_i     (result_data_i),
		.low_i      (state_reg.threshold_low_value),
		.high_i     (state_reg.threshold_high_value),
		// FIFO off masks the channel bit
		.watch_en_i (chan_threshold_watch_en && state_reg.fifo_en),
		.below_o    (cross_below),
		.above_o    (cross_above)
	);

	assign events = {cross_above, cross_below};

	// ==========================================================
	// Positive input code check
	// ==========================================================
	// Listed codes only; a table stays readable as the map grows
	always_comb
	begin
		sel_reserved = 1'b0;
		case (chan_sel)
			5'h02, 5'h03:
			begin
				sel_reserved = 1'b1;
			end
			5'h06, 5'h07:
			begin
				sel_reserved = 1'b1;
			end
			5'h08, 5'h09:
			begin
				sel_reserved = 1'b1;
			end
			5'h0C, 5'h0D:
			begin
				sel_reserved = 1'b1;
			end
			default:
			begin
				sel_reserved = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Read data for local registers
	// ==========================================================
	always_comb
	begin
		other_rd_data = '0;
		case (addr_i)
			CCF_ADDR_CTRL:
			begin
				other_rd_data[CCF_CTRL_FIFO_BIT] = state_reg.fifo_en;
				other_rd_data[CCF_CTRL_STBY_BIT] =
					state_reg.standby_switch_allow;
			end
			CCF_ADDR_THR_LO:
			begin
				other_rd_data[CCF_WORD_W-1:0] =
					state_reg.threshold_low_value;
			end
			CCF_ADDR_THR_HI:
			begin
				other_rd_data[CCF_WORD_W-1:0] =
					state_reg.threshold_high_value;
			end
			CCF_ADDR_STATUS:
			begin
				other_rd_data[CCF_ST_W-1:0] = state_reg.status;
			end
			CCF_ADDR_MASK:
			begin
				other_rd_data[CCF_ST_W-1:0] = state_reg.mask;
			end
			CCF_ADDR_LIVE:
			begin
				other_rd_data[CCF_LIVE_SW_BIT] = state_reg.switch_on;
				other_rd_data[CCF_LIVE_OK_BIT] = state_reg.pos_ok;
				other_rd_data[CCF_LIVE_SEL_LSB +: CCF_SEL_W] =
					state_reg.pos_sel;
			end
			default:
			begin
				other_rd_data = '0;
			end
		endcase
	end

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb
	begin
		state_next = state_reg;
		clr = '0;
		if (wr_i)
		begin
			case (addr_i)
				CCF_ADDR_CTRL:
				begin
					state_next.fifo_en = wr_data_i[CCF_CTRL_FIFO_BIT];
					state_next.standby_switch_allow =
						wr_data_i[CCF_CTRL_STBY_BIT];
				end
				CCF_ADDR_THR_LO:
				begin
					state_next.threshold_low_value =
						wr_data_i[CCF_WORD_W-1:0];
				end
				CCF_ADDR_THR_HI:
				begin
					state_next.threshold_high_value =
						wr_data_i[CCF_WORD_W-1:0];
				end
				CCF_ADDR_STATUS:
				begin
					clr = wr_data_i[CCF_ST_W-1:0];
				end
				CCF_ADDR_MASK:
				begin
					state_next.mask = wr_data_i[CCF_ST_W-1:0];
				end
				default:
				begin
					clr = '0;
				end
			endcase
		end
		// Set wins over a clear in the same cycle
		state_next.status = (state_reg.status & ~clr) | events;

		// Switch: every condition at once, else open
		state_next.switch_on = 1'b0;
		if (chan_low_side_switch_on && conv_active_i)
		begin
			case (pmode)
				CCF_PM_POWERDOWN:
				begin
					state_next.switch_on = 1'b0;
				end
				CCF_PM_STANDBY:
				begin
					state_next.switch_on =
						state_reg.standby_switch_allow;
				end
				CCF_PM_ACTIVE:
				begin
					state_next.switch_on = 1'b1;
				end
				CCF_PM_IDLE:
				begin
					state_next.switch_on = 1'b1;
				end
				default:
				begin
					state_next.switch_on = 1'b0;
				end
			endcase
		end

		// Selector only shown while a channel converts
		state_next.pos_sel = conv_active_i ? chan_sel : '0;
		state_next.pos_ok  = conv_active_i && !sel_reserved;

		state_next.irq = |(state_next.status & state_next.mask);
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state_reg.fifo_en              <= CCF_RST_CTRL[CCF_CTRL_FIFO_BIT];
			state_reg.standby_switch_allow <= CCF_RST_CTRL[CCF_CTRL_STBY_BIT];
			state_reg.threshold_low_value  <= CCF_RST_THR_LO;
			state_reg.threshold_high_value <= CCF_RST_THR_HI;
			state_reg.status               <= CCF_RST_ST;
			state_reg.mask                 <= CCF_RST_ST;
			state_reg.switch_on            <= 1'b0;
			state_reg.pos_sel              <= '0;
			state_reg.pos_ok               <= 1'b0;
			state_reg.irq                  <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign low_side_switch_pin_o     = state_reg.switch_on;
	assign chan_positive_input_sel_o = state_reg.pos_sel;
	assign positive_input_ok_o       = state_reg.pos_ok;
	assign irq_o                     = state_reg.irq;

endmodule : ccf_chan_cfg

// ---- ccf_chan_cfg_properties.sv ----
module ccf_chan_cfg_properties
	import ccf_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	// Register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [31:0] rd_data_o,
	// Conversion and outputs
	input  wire logic        conv_active_i,
	input  wire logic [1:0]  power_mode_i,
	input  wire logic        low_side_switch_pin_o,
	input  wire logic [4:0]  chan_positive_input_sel_o,
	input  wire logic        positive_input_ok_o,
	input  wire logic        irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	chk_rd_idle: assert property (
		!$past(rd_i) |-> rd_data_o == 32'h0000_0000)
		else $error("read data not zero outside read");
	chk_rd_unmap: assert property (
		rd_i && addr_i >= 8'h18 && addr_i < 8'h40
		|=> rd_data_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_sw_pd: assert property (
		power_mode_i == 2'h2 |=> !low_side_switch_pin_o)
		else $error("switch closed in power-down");
	chk_sw_idle: assert property (
		!conv_active_i |=> !low_side_switch_pin_o)
		else $error("switch closed without conversion");
	chk_sel_idle: assert property (
		!conv_active_i |=> chan_positive_input_sel_o == 5'h00)
		else $error("input select not zero when idle");
	chk_ok_resv: assert property (
		!chan_positive_input_sel_o[4] && chan_positive_input_sel_o[1]
		!= chan_positive_input_sel_o[3] |-> !positive_input_ok_o)
		else $error("reserved code flagged valid");
	chk_ok_valid: assert property (
		$past(conv_active_i) && (chan_positive_input_sel_o[4]
		|| chan_positive_input_sel_o[1] == chan_positive_input_sel_o[3])
		|-> positive_input_ok_o)
		else $error("valid code not flagged");
	chk_irq_masked: assert property (
		wr_i && addr_i == CCF_ADDR_MASK && wr_data_i[1:0] == 2'h0
		##1 !(wr_i && addr_i == CCF_ADDR_MASK) |=> !irq_o)
		else $error("interrupt high with zero mask");
endmodule : ccf_chan_cfg_properties

bind ccf_chan_cfg ccf_chan_cfg_properties i_chk (.clk_sys_i, .sys_rst_i,
	.addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .conv_active_i,
	.power_mode_i, .low_side_switch_pin_o, .chan_positive_input_sel_o,
	.positive_input_ok_o, .irq_o);

// ---- tb.sv ----
module tb
	import ccf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk, rst, wr, rd, act, rv, sw, ok, irq, en, ex;
	logic [7:0]  ad;
	logic [31:0] wd, rdat, q;
	logic [3:0]  ch;
	logic [1:0]  pm;
	logic [4:0]  sel;
	logic [23:0] rdv, w;
	logic [23:0] mdl [16];
	int          err_total, checked, seed, i;

	ccf_chan_cfg i_dut (.clk_sys_i(clk), .sys_rst_i(rst), .addr_i(ad),
		.wr_data_i(wd), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
		.conv_active_i(act), .conv_chan_i(ch), .power_mode_i(pm),
		.result_valid_i(rv), .result_data_i(rdv),
		.low_side_switch_pin_o(sw), .chan_positive_input_sel_o(sel),
		.positive_input_ok_o(ok), .irq_o(irq));

	// ==========================================
	// Tasks
	// ==========================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Gap cycle so a strobe is never set twice in one step
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		ad <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wreg

	task automatic rreg(input logic [7:0] a);
		ad <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		q = rdat;
		@(posedge clk);
	endtask : rreg

	task automatic wch(input int m, input logic [23:0] d);
		mdl[m] = d;
		wreg(8'h40 + 8'(4 * m), {8'h00, d});
	endtask : wch

	task automatic res(input logic [23:0] v);
		rdv <= v;
		rv <= 1'b1;
		@(posedge clk);
		rv <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : res

	task automatic look(ref logic s, input logic e);
		@(negedge clk);
		chk(32'(s), 32'(e));
		@(posedge clk);
	endtask : look

	task automatic stop_test;
		$display("Mismatches %0d, checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	// ==========================================
	// Clock, watchdog, sequence
	// ==========================================
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		stop_test();
	end

	initial
	begin
		{rst, wr, rd, act, rv} = 5'h10;
		{ad, wd, ch, pm, rdv} = '0;
		seed = 32'h7755_ba52;
		err_total = 0;
		checked = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rreg(8'h40);
		chk(q, 32'h0080_0000);
		rreg(8'h44);
		chk(q, 32'h0000_0000);
		rreg(CCF_ADDR_THR_HI);
		chk(q, 32'h00FF_FFFF);
		rreg(8'h20);
		chk(q, 32'h0000_0000);
		// Every code, switch bit, allow bit and mode once
		for (i = 0; i < 32; i++)
		begin
			w = 24'($random(seed));
			w[17:13] = 5'(i);
			w[9] = i[0];
			wch(i % 16, w);
			wreg(CCF_ADDR_CTRL, {30'h0, i[1], 1'b0});
			ch <= 4'(i);
			pm <= i[3:2];
			act <= 1'b1;
			repeat (3) @(posedge clk);
			@(negedge clk);
			en = i[0] && i[3:2] != 2'h2 && !(i[3:2] == 2'h1 && !i[1]);
			ex = w[17] || w[14] == w[16];
			chk(32'(sw), 32'(en));
			chk(32'(sel), 32'(mdl[i % 16][17:13]));
			chk(32'(ok), 32'(ex));
			@(posedge clk);
			rreg(CCF_ADDR_LIVE);
			chk(q, {19'h0_0000, 5'(i), 6'h00, ex, en});
			act <= 1'b0;
			@(posedge clk);
			rreg(8'h40 + 8'(4 * (i % 16)));
			chk(q, {8'h00, mdl[i % 16]});
		end
		wreg(CCF_ADDR_THR_LO, 32'h0000_0064);
		wreg(CCF_ADDR_THR_HI, 32'h0000_00C8);
		ch <= 4'h5;
		act <= 1'b1;
		pm <= 2'h0;
		for (i = 0; i < 4; i++)
		begin
			en = i[0] && i[1];
			wreg(CCF_ADDR_MASK, 32'h0000_0001);
			wreg(CCF_ADDR_CTRL, 32'(i[0]));
			wch(5, 24'(i[1]) << 18);
			res(24'h00_0064);
			res(24'h00_00C8);
			rreg(CCF_ADDR_STATUS);
			chk(q, 32'h0000_0000);
			res(24'h00_0063);
			res(24'h00_00C9);
			look(irq, en);
			rreg(CCF_ADDR_STATUS);
			chk(q, {30'h0, en, en});
			wreg(CCF_ADDR_STATUS, 32'h0000_0001);
			look(irq, 1'b0);
			rreg(CCF_ADDR_STATUS);
			chk(q, {30'h0, en, 1'b0});
			wreg(CCF_ADDR_MASK, 32'h0000_0000);
			wreg(CCF_ADDR_STATUS, 32'h0000_0002);
			rreg(CCF_ADDR_STATUS);
			chk(q, 32'h0000_0000);
		end
		stop_test();
	end
endmodule : tb
